// file: src/scrx_map.svh
/*
 * offsets, field positions, reset values and counts of the card receive path.
 * assumes word addressing over a 32-bit bus: byte address is four times the index.
 */
`ifndef SCRX_MAP_SVH
`define SCRX_MAP_SVH

// register indices and byte addresses
`define SCRX_IDX_STATUS 16'hFE08
`define SCRX_IDX_DATA 16'hFE09
`define SCRX_IDX_CTRL 16'hFE10
`define SCRX_IDX_IRQ_STAT 16'hFE11
`define SCRX_IDX_IRQ_MASK 16'hFE12
`define SCRX_ADDR_STATUS 32'h0003F820
`define SCRX_ADDR_DATA 32'h0003F824
`define SCRX_ADDR_CTRL 32'h0003F840
`define SCRX_ADDR_IRQ_STAT 32'h0003F844
`define SCRX_ADDR_IRQ_MASK 32'h0003F848

// receive_status fields
`define SCRX_ST_NINTH 7
`define SCRX_ST_FINAL 5
`define SCRX_ST_CKERR 4
`define SCRX_ST_FULL 3
`define SCRX_ST_EMPTY 2
`define SCRX_ST_OVR 1
`define SCRX_ST_PAR 0

// control fields
`define SCRX_CT_DIR 0
`define SCRX_CT_NINE 1
`define SCRX_CT_SYNC 2
`define SCRX_CT_BLOCK 3
`define SCRX_CT_CRC 4
`define SCRX_CT_ODD 5
`define SCRX_CTRL_W 6

// interrupt fields
`define SCRX_IRQ_ERR 0
`define SCRX_IRQ_BYTE 1
`define SCRX_IRQ_CKERR 2
`define SCRX_IRQ_W 3

// reset values and checksum constants
`define SCRX_DATA_RESET 8'h00
`define SCRX_CRC_INIT 16'hFFFF
`define SCRX_CRC_POLY 16'h1021
`define SCRX_CRC_RESIDUE 16'h1D0F
`define SCRX_LRC_EXPECT 8'h00

// fifo
`define SCRX_DEPTH 4
`define SCRX_PTR_W 2
`define SCRX_CNT_W 3

`endif

// file: src/scrx_pkg.sv
/*
 * types of the card receive path.
 * assumes scrx_map.svh on the include path.
 */
`include "scrx_map.svh"

package scrx_pkg;

    typedef enum logic [1:0] {
        SCRX_IDLE = 2'b00,
        SCRX_DATA = 2'b01,
        SCRX_NINTH = 2'b10
    } scrx_rx_e;

    typedef logic [`SCRX_DEPTH-1:0][7:0] scrx_mem_t;

    typedef struct packed {
        logic [2:0] clk_sync;
        logic [1:0] io_sync;
        scrx_rx_e rx;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic ninth;
        scrx_mem_t mem;
        logic [`SCRX_PTR_W-1:0] wr_ptr;
        logic [`SCRX_PTR_W-1:0] rd_ptr;
        logic [`SCRX_CNT_W-1:0] count;
        logic ovr;
        logic par;
        logic ckerr;
        logic final_flag;
        logic [15:0] crc;
        logic [7:0] lrc;
        logic [`SCRX_CTRL_W-1:0] ctrl;
        logic [`SCRX_IRQ_W-1:0] irq_stat;
        logic [`SCRX_IRQ_W-1:0] irq_mask;
        logic wr_pend;
        logic [31:0] wr_addr;
        logic [31:0] rdata;
    } scrx_state_s;

endpackage

// file: src/scrx_receive.sv
/*
 * receive path of a smart card serial interface behind an ahb-lite slave:
 * bit sampler on the card clock, receive fifo, parity, crc/lrc check, ninth bit,
 * status, interrupt status and mask.
 * assumes card_clk and card_io come from outside the clock domain, and a single
 * ahb-lite master issuing whole-word single transfers.
 */
`timescale 1ns/10ps

module scrx_receive (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // card link
    input wire logic card_clk,
    input wire logic card_io,
    // events
    output logic receive_error_event,
    output logic irq
);

    function automatic logic [2:0] reg_sel(input logic [31:0] a);
        logic [2:0] s;
        s = 3'h0;
        unique case (a)
            `SCRX_ADDR_STATUS: s = 3'h1;
            `SCRX_ADDR_DATA: s = 3'h2;
            `SCRX_ADDR_CTRL: s = 3'h3;
            `SCRX_ADDR_IRQ_STAT: s = 3'h4;
            `SCRX_ADDR_IRQ_MASK: s = 3'h5;
            default: s = 3'h0;
        endcase
        return s;
    endfunction

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ `SCRX_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    scrx_pkg::scrx_state_s st_reg;
    scrx_pkg::scrx_state_s st_next;

    logic card_rise;
    logic io_bit;
    logic byte_done;
    logic [7:0] byte_val;
    logic par_bad;
    logic ninth_done;
    logic rd_take;
    logic [2:0] rd_sel;
    logic status_read;
    logic data_read;
    logic [2:0] wr_sel;
    logic fifo_full;
    logic fifo_empty;
    logic do_pop;
    logic do_push;
    logic ovr_event;
    logic [15:0] crc_new;
    logic [7:0] lrc_new;
    logic ck_fail;
    logic [`SCRX_IRQ_W-1:0] irq_set;
    logic [`SCRX_IRQ_W-1:0] irq_clr;
    logic [7:0] status_val;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_reg.rdata;

    always_comb begin
        st_next = st_reg;
        byte_done = 1'b0;
        byte_val = st_reg.shift;
        par_bad = 1'b0;
        ninth_done = 1'b0;

        // synchronisers: stage 0 is read only by stage 1
        st_next.clk_sync = {st_reg.clk_sync[1:0], card_clk};
        st_next.io_sync = {st_reg.io_sync[0], card_io};
        card_rise = st_reg.clk_sync[1] & ~st_reg.clk_sync[2];
        io_bit = st_reg.io_sync[1];

        // bit sampler, active in receive direction only
        if (st_reg.ctrl[`SCRX_CT_DIR]) begin
            st_next.rx = scrx_pkg::SCRX_IDLE;
            st_next.bit_cnt = 3'h0;
        end else if (card_rise) begin
            unique case (st_reg.rx)
                scrx_pkg::SCRX_IDLE: begin
                    if (st_reg.ctrl[`SCRX_CT_SYNC]) begin
                        st_next.shift = {io_bit, st_reg.shift[7:1]};
                        st_next.bit_cnt = 3'h1;
                        st_next.rx = scrx_pkg::SCRX_DATA;
                    end else if (!io_bit) begin
                        st_next.bit_cnt = 3'h0;
                        st_next.rx = scrx_pkg::SCRX_DATA;
                    end
                end
                scrx_pkg::SCRX_DATA: begin
                    st_next.shift = {io_bit, st_reg.shift[7:1]};
                    byte_val = {io_bit, st_reg.shift[7:1]};
                    st_next.bit_cnt = 3'(st_reg.bit_cnt + 3'h1);
                    if (st_reg.bit_cnt == 3'h7) begin
                        if (st_reg.ctrl[`SCRX_CT_SYNC] && !st_reg.ctrl[`SCRX_CT_NINE]) begin
                            byte_done = 1'b1;
                            st_next.rx = scrx_pkg::SCRX_IDLE;
                        end else begin
                            st_next.rx = scrx_pkg::SCRX_NINTH;
                        end
                    end
                end
                scrx_pkg::SCRX_NINTH: begin
                    byte_done = 1'b1;
                    st_next.rx = scrx_pkg::SCRX_IDLE;
                    if (st_reg.ctrl[`SCRX_CT_SYNC]) begin
                        ninth_done = 1'b1;
                        st_next.ninth = io_bit;
                    end else begin
                        par_bad = (^{st_reg.shift, io_bit}) != st_reg.ctrl[`SCRX_CT_ODD];
                    end
                end
                default: st_next.rx = scrx_pkg::SCRX_IDLE;
            endcase
        end

        // bus address phase
        rd_take = hsel & hready & htrans[1] & ~hwrite;
        rd_sel = rd_take ? reg_sel(haddr) : 3'h0;
        status_read = rd_sel == 3'h1;
        data_read = rd_sel == 3'h2;
        wr_sel = st_reg.wr_pend ? reg_sel(st_reg.wr_addr) : 3'h0;
        st_next.wr_pend = hsel & hready & htrans[1] & hwrite;
        st_next.wr_addr = haddr;

        // fifo
        fifo_full = st_reg.count == `SCRX_CNT_W'(`SCRX_DEPTH);
        fifo_empty = st_reg.count == `SCRX_CNT_W'(0);
        do_pop = data_read & ~fifo_empty;
        ovr_event = byte_done & fifo_full & ~st_reg.ovr;
        do_push = byte_done & ~fifo_full & ~st_reg.ovr;
        if (do_push) begin
            st_next.mem[st_reg.wr_ptr] = byte_val;
            st_next.wr_ptr = `SCRX_PTR_W'(st_reg.wr_ptr + 1'b1);
        end
        if (do_pop) begin
            st_next.rd_ptr = `SCRX_PTR_W'(st_reg.rd_ptr + 1'b1);
        end
        st_next.count = `SCRX_CNT_W'(st_reg.count + {2'b00, do_push} - {2'b00, do_pop});

        // checksum accumulation and closing check
        crc_new = crc_step(st_reg.crc, byte_val);
        lrc_new = st_reg.lrc ^ byte_val;
        ck_fail = 1'b0;
        if (byte_done) begin
            st_next.crc = crc_new;
            st_next.lrc = lrc_new;
            if (st_reg.final_flag && st_reg.ctrl[`SCRX_CT_BLOCK]) begin
                ck_fail = st_reg.ctrl[`SCRX_CT_CRC] ? (crc_new != `SCRX_CRC_RESIDUE)
                    : (lrc_new != `SCRX_LRC_EXPECT);
            end
        end

        // status flags: a status read clears overrun and parity, a fresh event wins
        if (status_read) begin
            st_next.ovr = 1'b0;
            st_next.par = 1'b0;
        end
        if (byte_done && fifo_full) begin
            st_next.ovr = 1'b1;
        end
        if (par_bad) begin
            st_next.par = 1'b1;
        end
        if (ck_fail) begin
            st_next.ckerr = 1'b1;
        end

        status_val = {st_reg.ninth, 1'b0, st_reg.final_flag, st_reg.ckerr, fifo_full, fifo_empty,
            st_reg.ovr, st_reg.par};

        // register writes in the data phase
        irq_clr = '0;
        unique case (wr_sel)
            3'h1: st_next.final_flag = hwdata[`SCRX_ST_FINAL];
            3'h3: st_next.ctrl = hwdata[`SCRX_CTRL_W-1:0];
            3'h4: irq_clr = hwdata[`SCRX_IRQ_W-1:0];
            3'h5: st_next.irq_mask = hwdata[`SCRX_IRQ_W-1:0];
            default: irq_clr = '0;
        endcase

        // direction change restarts the checksum logic
        if (st_next.ctrl[`SCRX_CT_DIR] != st_reg.ctrl[`SCRX_CT_DIR]) begin
            st_next.crc = `SCRX_CRC_INIT;
            st_next.lrc = `SCRX_LRC_EXPECT;
            st_next.ckerr = 1'b0;
        end

        // interrupt status: set wins over write-one clear, empty feeds nothing
        irq_set = '0;
        irq_set[`SCRX_IRQ_ERR] = ovr_event | par_bad;
        irq_set[`SCRX_IRQ_BYTE] = do_push;
        irq_set[`SCRX_IRQ_CKERR] = ck_fail;
        st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_set;

        // read data of the address phase
        unique case (rd_sel)
            3'h1: st_next.rdata = {24'h000000, status_val};
            3'h2: st_next.rdata = {24'h000000, fifo_empty ? `SCRX_DATA_RESET : st_reg.mem[st_reg.rd_ptr]};
            3'h3: st_next.rdata = {26'h0, st_reg.ctrl};
            3'h4: st_next.rdata = {29'h0, st_reg.irq_stat};
            3'h5: st_next.rdata = {29'h0, st_reg.irq_mask};
            default: st_next.rdata = 32'h00000000;
        endcase
    end

    assign receive_error_event = ovr_event | par_bad;
    assign irq = |(st_reg.irq_stat & st_reg.irq_mask);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.crc <= `SCRX_CRC_INIT;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    full_flag_a: assert property (st_reg.count == `SCRX_CNT_W'(`SCRX_DEPTH) |-> status_val[`SCRX_ST_FULL])
        else $error("full bit low with fifo at depth");
    overrun_sets_a: assert property (byte_done && fifo_full |=> st_reg.ovr)
        else $error("overrun not set on byte into full fifo");
    overrun_event_a: assert property (byte_done && fifo_full && !st_reg.ovr |-> receive_error_event)
        else $error("no error event on overrun");
    status_clear_a: assert property (status_read && !byte_done |=> !st_reg.ovr)
        else $error("overrun survived status read");
    overrun_discard_a: assert property (st_reg.ovr && byte_done && !do_pop |=> st_reg.count == $past(st_reg.count))
        else $error("byte stored during overrun");
    parity_sets_a: assert property (par_bad |-> receive_error_event ##1 st_reg.par)
        else $error("parity error not flagged");
    push_count_a: assert property (do_push && !do_pop |=> st_reg.count == $past(st_reg.count) + 1'b1)
        else $error("fifo count not advanced on push");
    ninth_capture_a: assert property (ninth_done |=> st_reg.ninth == $past(io_bit))
        else $error("ninth bit not captured");
    crc_fail_a: assert property (byte_done && st_reg.final_flag && st_reg.ctrl[`SCRX_CT_BLOCK]
        && st_reg.ctrl[`SCRX_CT_CRC] && crc_new != `SCRX_CRC_RESIDUE
        && st_next.ctrl[`SCRX_CT_DIR] == st_reg.ctrl[`SCRX_CT_DIR] |=> st_reg.ckerr)
        else $error("crc mismatch not flagged");
    lrc_fail_a: assert property (byte_done && st_reg.final_flag && st_reg.ctrl[`SCRX_CT_BLOCK]
        && !st_reg.ctrl[`SCRX_CT_CRC] && lrc_new != `SCRX_LRC_EXPECT
        && st_next.ctrl[`SCRX_CT_DIR] == st_reg.ctrl[`SCRX_CT_DIR] |=> st_reg.ckerr)
        else $error("lrc mismatch not flagged");
    dir_reinit_a: assert property ($changed(st_reg.ctrl[`SCRX_CT_DIR]) |-> st_reg.crc == `SCRX_CRC_INIT
        && st_reg.lrc == `SCRX_LRC_EXPECT)
        else $error("checksum not reinitialised on direction change");
    empty_quiet_a: assert property ($rose(status_val[`SCRX_ST_EMPTY]) |-> !$rose(st_reg.irq_stat[`SCRX_IRQ_BYTE]))
        else $error("empty change raised byte interrupt");

endmodule

// file: tb/scrx_card_model.sv
/*
 * card model for the receive path bench: makes the card clock and the io level.
 * assumes the bench calls send() only while the receive path is idle.
 */
`timescale 1ns/10ps

module scrx_card_model (
    // card pins
    output logic card_clk,
    output logic card_io
);
    // clock stands low between frames, io is pulled up when released
    initial begin
        card_clk = 1'b0;
        card_io = 1'b1;
    end

    // async: start, 8 bits lsb first, parity; sync: 8 bits lsb first, ninth if asked
    task automatic send(input logic [7:0] d, input logic sync, input logic odd, input logic flip,
                        input logic nine, input logic ninth);
        logic [9:0] bits;
        int n;
        bits = sync ? {1'b0, ninth, d} : {^d ^ odd ^ flip, d, 1'b0};
        n = sync ? (nine ? 9 : 8) : 10;
        for (int i = 0; i < n; i++) begin
            card_io = bits[i];
            #32 card_clk = 1'b1;
            #32 card_clk = 1'b0;
        end
        card_io = 1'b1;
    endtask
endmodule

// file: tb/smart_card_receive_path_tb.sv
/*
 * self-checking bench of the card receive path.
 * assumes scrx_map.svh on the include path and the card model beside it.
 */
`timescale 1ns/10ps
`include "scrx_map.svh"

module smart_card_receive_path_tb;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] d;
        logic [7:0] st;
    } scrx_row_s;

    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic card_clk;
    logic card_io;
    logic receive_error_event;
    logic irq;
    int num_errors = 0;
    int total_checks = 0;
    int ev_cnt = 0;
    logic [31:0] rd;
    logic [15:0] crc;
    logic [15:0] pair;
    scrx_row_s rows [4] = '{'{8'h00, 8'hA5, 8'h00}, '{8'h20, 8'h3C, 8'h00},
                            '{8'h06, 8'h96, 8'h80}, '{8'h06, 8'h69, 8'h00}};

    always #2.5 clk = ~clk;
    assign hready = hreadyout;
    always @(posedge clk) if (receive_error_event === 1'b1) ev_cnt <= ev_cnt + 1;

    scrx_receive DUT (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .card_clk(card_clk), .card_io(card_io),
        .receive_error_event(receive_error_event), .irq(irq));
    scrx_card_model card (.card_clk(card_clk), .card_io(card_io));

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one single ahb-lite transfer, read data left in rd
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(name, rd & m, exp);
    endtask

    function automatic logic [15:0] crc_f(input logic [15:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `SCRX_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction

    // async byte with the final flag as given, then popped back
    task automatic byte_in(input logic [7:0] d, input logic fin);
        bus(1'b1, `SCRX_ADDR_STATUS, {26'h0, fin, 5'h0});
        card.send(d, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rchk("data", `SCRX_ADDR_DATA, 32'hFF, {24'h0, d});
        crc = crc_f(crc, d);
    endtask

    task automatic dir_flip(input logic [7:0] c);
        bus(1'b1, `SCRX_ADDR_CTRL, {24'h0, c | 8'h01});
        bus(1'b1, `SCRX_ADDR_CTRL, {24'h0, c});
        crc = `SCRX_CRC_INIT;
    endtask

    initial begin
        #300000;
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        chk("irq", {31'h0, irq}, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        chk("hreadyout", {31'h0, hreadyout}, 32'h1);
        rchk("status", `SCRX_ADDR_STATUS, 32'hFFFFFFFF, 32'h04);
        rchk("data", `SCRX_ADDR_DATA, 32'hFFFFFFFF, 32'h0);
        rchk("ctrl", `SCRX_ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
        rchk("irq stat", `SCRX_ADDR_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
        rchk("irq mask", `SCRX_ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
        rchk("unmapped", 32'h0003F830, 32'hFFFFFFFF, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, `SCRX_ADDR_CTRL, {24'h0, rows[i].ctrl});
            card.send(rows[i].d, rows[i].ctrl[2], rows[i].ctrl[5], 1'b0, rows[i].ctrl[1], rows[i].st[7]);
            rchk("status", `SCRX_ADDR_STATUS, 32'hFF, {24'h0, rows[i].st});
            rchk("data", `SCRX_ADDR_DATA, 32'hFF, {24'h0, rows[i].d});
        end
        chk("irq", {31'h0, irq}, 32'h0);
        rchk("irq stat", `SCRX_ADDR_IRQ_STAT, 32'h7, 32'h2);
        bus(1'b1, `SCRX_ADDR_IRQ_MASK, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        bus(1'b1, `SCRX_ADDR_IRQ_STAT, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        bus(1'b1, `SCRX_ADDR_CTRL, 32'h0);
        for (int i = 0; i < 6; i++) begin
            card.send(8'h10 + 8'(i), 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        end
        rchk("status", `SCRX_ADDR_STATUS, 32'hFF, 32'h0A);
        chk("events", ev_cnt, 32'd1);
        rchk("status", `SCRX_ADDR_STATUS, 32'hFF, 32'h08);
        bus(1'b1, `SCRX_ADDR_IRQ_STAT, 32'h7);
        for (int i = 0; i < 4; i++) begin
            rchk("data", `SCRX_ADDR_DATA, 32'hFF, 32'h10 + i);
        end
        rchk("status", `SCRX_ADDR_STATUS, 32'hFF, 32'h04);
        rchk("irq stat", `SCRX_ADDR_IRQ_STAT, 32'h7, 32'h0);
        card.send(8'h33, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        rchk("parity", `SCRX_ADDR_STATUS, 32'h01, 32'h01);
        rchk("parity", `SCRX_ADDR_STATUS, 32'h01, 32'h00);
        chk("events", ev_cnt, 32'd2);
        bus(1'b0, `SCRX_ADDR_DATA, 32'h0);
        dir_flip(8'h08);
        byte_in(8'h12, 1'b0);
        byte_in(8'h12, 1'b1);
        rchk("ckerr", `SCRX_ADDR_STATUS, 32'h10, 32'h00);
        byte_in(8'h55, 1'b1);
        rchk("ckerr", `SCRX_ADDR_STATUS, 32'h10, 32'h10);
        dir_flip(8'h18);
        rchk("ckerr", `SCRX_ADDR_STATUS, 32'h10, 32'h00);
        for (int i = 0; i < 65536; i++) begin
            if (crc_f(crc_f(`SCRX_CRC_INIT, i[15:8]), i[7:0]) == `SCRX_CRC_RESIDUE) pair = 16'(i);
        end
        byte_in(pair[15:8], 1'b0);
        byte_in(pair[7:0], 1'b1);
        rchk("ckerr", `SCRX_ADDR_STATUS, 32'h10, 32'h00);
        byte_in(8'hC3, 1'b1);
        rchk("ckerr", `SCRX_ADDR_STATUS, 32'h10, (crc != `SCRX_CRC_RESIDUE) ? 32'h10 : 32'h0);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rchk("status", `SCRX_ADDR_STATUS, 32'hFFFFFFFF, 32'h04);
        rchk("ctrl", `SCRX_ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
        rchk("data", `SCRX_ADDR_DATA, 32'hFFFFFFFF, 32'h0);
        stop_test();
    end
endmodule
